// File: rtl/ccr_pkg.sv
// ccr_pkg: addresses, field positions, reset values and conversion constants
// of the charger configuration register bank.
// assumes a single 10 MHz clock domain and 8-bit register data.
package ccr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register addresses
   localparam logic [7:0] CCR_ADDR_CURR = 8'h03;
   localparam logic [7:0] CCR_ADDR_VOLT = 8'h04;
   localparam logic [7:0] CCR_ADDR_CTL1 = 8'h05;
   localparam logic [7:0] CCR_ADDR_CTL2 = 8'h06;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] CCR_RST_CURR = 8'h12;
   localparam logic [7:0] CCR_RST_VOLT = 8'h40;
   localparam logic [7:0] CCR_RST_CTL1 = 8'h9E;
   localparam logic [7:0] CCR_RST_CTL2 = 8'hE6;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CCR_PRE_MSB = 7;
   localparam int CCR_PRE_LSB = 4;
   localparam int CCR_TERM_MSB = 3;
   localparam int CCR_TERM_LSB = 0;
   localparam int CCR_VCODE_MSB = 7;
   localparam int CCR_VCODE_LSB = 3;
   localparam int CCR_TOPUP_MSB = 2;
   localparam int CCR_TOPUP_LSB = 1;
   localparam int CCR_RECHG_BIT = 0;
   localparam int CCR_TERMEN_BIT = 7;
   localparam int CCR_WDOG_MSB = 5;
   localparam int CCR_WDOG_LSB = 4;
   localparam int CCR_TMREN_BIT = 3;
   localparam int CCR_FCT_BIT = 2;
   localparam int CCR_THERM_BIT = 1;
   localparam int CCR_WARM_BIT = 0;
   localparam int CCR_OVSEL_MSB = 7;
   localparam int CCR_OVSEL_LSB = 6;
   localparam int CCR_VIN_MSB = 3;
   localparam int CCR_VIN_LSB = 0;

   ////////////////////////////////////////////////////////////////////////////
   // current and voltage conversion
   localparam logic [3:0] CCR_CUR_CLAMP = 4'hC;
   localparam logic [9:0] CCR_CUR_BASE_MA = 10'h014;
   localparam logic [9:0] CCR_CUR_STEP_MA = 10'h014;
   localparam logic [12:0] CCR_VIN_BASE_MV = 13'h0F3C;
   localparam logic [12:0] CCR_VIN_STEP_MV = 13'h0064;

   // codes beyond the top step act as the top step
   function automatic logic [3:0] ccr_clamp(input logic [3:0] code);
      ccr_clamp = (code > CCR_CUR_CLAMP) ? CCR_CUR_CLAMP : code;
   endfunction

   function automatic logic [9:0] ccr_cur_ma(input logic [3:0] code);
      ccr_cur_ma = 10'(CCR_CUR_BASE_MA + CCR_CUR_STEP_MA * {6'h00, ccr_clamp(code)});
   endfunction

endpackage

// File: rtl/ccr_decode.sv
// ccr_decode: turns stored current and input-voltage codes into the values
// the analog side acts on.
// assumes codes come straight from the register flops of the same clock.
`timescale 1ns/1ns
module ccr_decode
   import ccr_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] pre_code_i,
   input wire logic [3:0] term_code_i,
   input wire logic [3:0] vin_code_i,
   output logic [3:0] pre_eff_o,
   output logic [3:0] term_eff_o,
   output logic [9:0] pre_ma_o,
   output logic [9:0] term_ma_o,
   output logic [12:0] vin_mv_o
);

   logic [3:0] pre_eff_nxt;
   logic [3:0] term_eff_nxt;
   logic [9:0] pre_ma_nxt;
   logic [9:0] term_ma_nxt;
   logic [12:0] vin_mv_nxt;

   always_comb begin
      pre_eff_nxt = ccr_clamp(pre_code_i);
      term_eff_nxt = ccr_clamp(term_code_i);
      pre_ma_nxt = ccr_cur_ma(pre_code_i);
      term_ma_nxt = ccr_cur_ma(term_code_i);
      vin_mv_nxt = 13'(CCR_VIN_BASE_MV + CCR_VIN_STEP_MV * {9'h000, vin_code_i});
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pre_eff_o <= CCR_RST_CURR[CCR_PRE_MSB:CCR_PRE_LSB];
         term_eff_o <= CCR_RST_CURR[CCR_TERM_MSB:CCR_TERM_LSB];
         pre_ma_o <= ccr_cur_ma(CCR_RST_CURR[CCR_PRE_MSB:CCR_PRE_LSB]);
         term_ma_o <= ccr_cur_ma(CCR_RST_CURR[CCR_TERM_MSB:CCR_TERM_LSB]);
         vin_mv_o <= 13'(CCR_VIN_BASE_MV + CCR_VIN_STEP_MV
            * {9'h000, CCR_RST_CTL2[CCR_VIN_MSB:CCR_VIN_LSB]});
      end else begin
         pre_eff_o <= pre_eff_nxt;
         term_eff_o <= term_eff_nxt;
         pre_ma_o <= pre_ma_nxt;
         term_ma_o <= term_ma_nxt;
         vin_mv_o <= vin_mv_nxt;
      end
   end

endmodule

// File: rtl/ccr_regs.sv
// ccr_regs: four 8-bit charger configuration registers behind the byte-level
// register port of the serial host interface, with field outputs.
// assumes the serial front end delivers one-cycle write and read strobes.
//
// Contract
// - precharge code bits 7:4, 20 mA offset, 20 mA step, default 40 mA.
// - precharge codes above 1100 act as 260 mA.
// - termination code bits 3:0, 20 mA offset and step, default 60 mA.
// - termination codes above 1100 are clamped to 260 mA.
// - charge voltage code bits 7:3 of voltage register, default 01000.
// - top-off timer bits 2:1, default disabled.
// - recharge threshold bit 0, default 120 mV.
// - termination enable bit 7 of control one, default set.
// - safety timer enable bit 3, default enabled.
// - fast charge timer select bit 2, default 10 hours.
// - warm zone voltage select bit 0, default 4.1 V limit.
// - overvoltage select bits 7:6 of control two, restored only by register or system reset.
// - input voltage limit bits 3:0, default 0110, ignores watchdog expiry.
`timescale 1ns/1ns
module ccr_regs
   import ccr_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic reg_rst_i,
   input wire logic wdog_expire_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic [3:0] precharge_current_code_o,
   output logic [3:0] termination_current_code_o,
   output logic [9:0] precharge_ma_o,
   output logic [9:0] termination_ma_o,
   output logic [4:0] charge_voltage_code_o,
   output logic [1:0] topup_duration_o,
   output logic recharge_threshold_sel_o,
   output logic term_en_o,
   output logic [1:0] wdog_period_o,
   output logic safety_timer_en_o,
   output logic fast_charge_timer_sel_o,
   output logic thermal_limit_sel_o,
   output logic warm_zone_voltage_sel_o,
   output logic [1:0] input_overvoltage_sel_o,
   output logic [3:0] input_voltage_limit_code_o,
   output logic [12:0] input_voltage_limit_mv_o
);

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic [7:0] curr_r;
   logic [7:0] curr_nxt;
   logic [7:0] volt_r;
   logic [7:0] volt_nxt;
   logic [7:0] ctl1_r;
   logic [7:0] ctl1_nxt;
   logic [7:0] ctl2_r;
   logic [7:0] ctl2_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;

   // unmapped addresses read as zero
   function automatic logic [7:0] rd_mux(input logic [7:0] addr, input logic [7:0] c,
                                         input logic [7:0] v, input logic [7:0] k1,
                                         input logic [7:0] k2);
      if (addr == CCR_ADDR_CURR) begin
         rd_mux = c;
      end else if (addr == CCR_ADDR_VOLT) begin
         rd_mux = v;
      end else if (addr == CCR_ADDR_CTL1) begin
         rd_mux = k1;
      end else if (addr == CCR_ADDR_CTL2) begin
         rd_mux = k2;
      end else begin
         rd_mux = 8'h00;
      end
   endfunction

   always_comb begin
      curr_nxt = curr_r;
      volt_nxt = volt_r;
      ctl1_nxt = ctl1_r;
      ctl2_nxt = ctl2_r;
      rvalid_nxt = reg_rd_i;
      rdata_nxt = reg_rd_i ? rd_mux(reg_addr_i, curr_r, volt_r, ctl1_r, ctl2_r) : rdata_r;
      // reserved bits are stored as written; keeping them at reset value is
      // the host's duty
      // reserved bits stored
      if (reg_wr_i) begin
         if (reg_addr_i == CCR_ADDR_CURR) begin
            curr_nxt = reg_wdata_i;
         end else if (reg_addr_i == CCR_ADDR_VOLT) begin
            volt_nxt = reg_wdata_i;
         end else if (reg_addr_i == CCR_ADDR_CTL1) begin
            ctl1_nxt = reg_wdata_i;
         end else if (reg_addr_i == CCR_ADDR_CTL2) begin
            ctl2_nxt = reg_wdata_i;
         end
      end
      // watchdog restore beats a same-cycle write so a stale host cannot
      // keep its settings alive
      // watchdog restore
      if (wdog_expire_i) begin
         curr_nxt = CCR_RST_CURR;
         volt_nxt = CCR_RST_VOLT;
         ctl1_nxt = CCR_RST_CTL1;
      end
      if (reg_rst_i) begin
         curr_nxt = CCR_RST_CURR;
         volt_nxt = CCR_RST_VOLT;
         ctl1_nxt = CCR_RST_CTL1;
         ctl2_nxt = CCR_RST_CTL2;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         curr_r <= CCR_RST_CURR;
         volt_r <= CCR_RST_VOLT;
         ctl1_r <= CCR_RST_CTL1;
         ctl2_r <= CCR_RST_CTL2;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         curr_r <= curr_nxt;
         volt_r <= volt_nxt;
         ctl1_r <= ctl1_nxt;
         ctl2_r <= ctl2_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field outputs

   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;
   assign charge_voltage_code_o = volt_r[CCR_VCODE_MSB:CCR_VCODE_LSB];
   assign topup_duration_o = volt_r[CCR_TOPUP_MSB:CCR_TOPUP_LSB];
   assign recharge_threshold_sel_o = volt_r[CCR_RECHG_BIT];
   assign term_en_o = ctl1_r[CCR_TERMEN_BIT];
   assign wdog_period_o = ctl1_r[CCR_WDOG_MSB:CCR_WDOG_LSB];
   assign safety_timer_en_o = ctl1_r[CCR_TMREN_BIT];
   assign fast_charge_timer_sel_o = ctl1_r[CCR_FCT_BIT];
   assign thermal_limit_sel_o = ctl1_r[CCR_THERM_BIT];
   assign warm_zone_voltage_sel_o = ctl1_r[CCR_WARM_BIT];
   assign input_overvoltage_sel_o = ctl2_r[CCR_OVSEL_MSB:CCR_OVSEL_LSB];
   assign input_voltage_limit_code_o = ctl2_r[CCR_VIN_MSB:CCR_VIN_LSB];

   // decoded values are one cycle behind the stored codes
   ccr_decode u_decode (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pre_code_i(curr_r[CCR_PRE_MSB:CCR_PRE_LSB]),
      .term_code_i(curr_r[CCR_TERM_MSB:CCR_TERM_LSB]),
      .vin_code_i(ctl2_r[CCR_VIN_MSB:CCR_VIN_LSB]),
      .pre_eff_o(precharge_current_code_o),
      .term_eff_o(termination_current_code_o),
      .pre_ma_o(precharge_ma_o),
      .term_ma_o(termination_ma_o),
      .vin_mv_o(input_voltage_limit_mv_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   logic quiet;
   assign quiet = !reg_rst_i && !wdog_expire_i;

   sequence seq_wr_volt;
      reg_wr_i && reg_addr_i == CCR_ADDR_VOLT && quiet;
   endsequence

   sequence seq_rd_volt;
      reg_rd_i && reg_addr_i == CCR_ADDR_VOLT && !reg_wr_i;
   endsequence

   sequence seq_wr_ctl1;
      reg_wr_i && reg_addr_i == CCR_ADDR_CTL1 && quiet;
   endsequence

   // idle cycle between a write and the read that checks it
   sequence seq_gap;
      !reg_wr_i && quiet;
   endsequence

   sequence seq_restore;
      reg_rst_i || wdog_expire_i;
   endsequence

   AST_PRE_CLAMP: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $past(curr_r[CCR_PRE_MSB:CCR_PRE_LSB]) > CCR_CUR_CLAMP && !$rose(sys_rst_i)
      |-> precharge_current_code_o == CCR_CUR_CLAMP && precharge_ma_o == 10'h104)
      else $error("precharge code not clamped");

   AST_TERM_CLAMP: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      termination_current_code_o <= CCR_CUR_CLAMP && termination_ma_o <= 10'h104)
      else $error("termination current above top step");

   AST_PRE_MA: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == CCR_ADDR_CURR && quiet && reg_wdata_i[7:4] == 4'h1
      ##1 !reg_wr_i && quiet |=> precharge_ma_o == 10'h028)
      else $error("precharge code one is not 40 mA");

   AST_TERM_MA: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_rst_i ##1 !reg_wr_i && !wdog_expire_i |=> termination_ma_o == 10'h03C)
      else $error("default termination current is not 60 mA");

   AST_VOLT_WRITE: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_wr_volt |=> charge_voltage_code_o == $past(reg_wdata_i[7:3])
         && topup_duration_o == $past(reg_wdata_i[2:1]))
      else $error("voltage register write lost");

   AST_READBACK: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_wr_volt ##1 seq_gap ##1 seq_gap ##1 (seq_rd_volt and quiet) |=> reg_rvalid_o
         && reg_rdata_o == $past(reg_wdata_i, 4))
      else $error("voltage register readback differs");

   AST_CTL1_WRITE: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_wr_ctl1 |=> {term_en_o, wdog_period_o, safety_timer_en_o,
         fast_charge_timer_sel_o, thermal_limit_sel_o, warm_zone_voltage_sel_o}
         == {$past(reg_wdata_i[7]), $past(reg_wdata_i[5:0])})
      else $error("control one fields do not follow write");

   AST_WDOG_RESTORE: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      wdog_expire_i |=> curr_r == CCR_RST_CURR && volt_r == CCR_RST_VOLT
         && ctl1_r == CCR_RST_CTL1 && term_en_o && wdog_period_o == 2'h1)
      else $error("watchdog did not restore defaults");

   AST_CTL2_KEEP: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      wdog_expire_i && !reg_rst_i && !reg_wr_i |=> $stable(ctl2_r)
         ##1 $stable(input_voltage_limit_mv_o))
      else $error("watchdog disturbed control two");

   AST_REG_RST: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_rst_i |=> input_overvoltage_sel_o == 2'h3 && input_voltage_limit_code_o == 4'h6
         ##1 input_voltage_limit_mv_o == 13'h1194)
      else $error("register reset did not restore control two");

   AST_TOPUP_DEFAULT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_restore |=> topup_duration_o == 2'h0 && charge_voltage_code_o == 5'h08)
      else $error("top-off default not restored");

   AST_TERM_EN_DEFAULT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_restore |=> term_en_o)
      else $error("termination enable default not restored");

   AST_SAFETY_DEFAULT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_restore |=> safety_timer_en_o)
      else $error("safety timer enable default not restored");

   AST_FCT_DEFAULT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_restore |=> fast_charge_timer_sel_o)
      else $error("fast charge timer default not restored");

   AST_THERM_DEFAULT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_restore |=> thermal_limit_sel_o)
      else $error("thermal limit default not restored");

   AST_WARM_DEFAULT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_restore |=> !warm_zone_voltage_sel_o && !recharge_threshold_sel_o)
      else $error("warm zone voltage default not restored");

endmodule

// File: dv/ccr_host_model.sv
// ccr_host_model: host side that programs the charger registers over the
// byte strobe port; the bench calls its wr and rd tasks.
// assumes the register bank samples strobes on the rising clock edge.
`timescale 1ns/1ns
module ccr_host_model
   import ccr_pkg::*;
(
   input wire logic clk_i,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   logic [7:0] sent_r;

   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      sent_r = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == CCR_ADDR_CTL1) begin
         v[6] = CCR_RST_CTL1[6];
      end
      if (a == CCR_ADDR_CTL2) begin
         v[5:4] = CCR_RST_CTL2[5:4];
      end
      sent_r = v;
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= v;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      // stale lines must not look valid after release
      reg_addr_o <= ~a;
      reg_wdata_o <= ~v;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
   endtask
endmodule

// File: dv/charger_config_regs_test.sv
// charger_config_regs_test: self-checking bench for the configuration bank.
// assumes the bank answers reads one cycle after the strobe, fields a cycle
// after a write and decoded values a cycle after that.
`timescale 1ns/1ns
module charger_config_regs_test
   import ccr_pkg::*;
;
   localparam int TMO = 5000;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic reg_rst_i = 1'b0;
   logic wdog_expire_i = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, reg_rvalid;
   logic [3:0] pre_code, term_code, vin_code;
   logic [9:0] pre_ma, term_ma;
   logic [4:0] vcode;
   logic [1:0] topup, wdog_per, ov_sel;
   logic rechg, term_en, tmr_en, fct, therm, warm;
   logic [12:0] vin_mv;
   logic [15:0] exp_q[$];
   logic [31:0] lfsr_r = 32'hC54A599B;
   logic [7:0] d;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc_cnt = 0;
   int e;

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   ccr_host_model host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
      .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

   ccr_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rst_i(reg_rst_i),
      .wdog_expire_i(wdog_expire_i), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
      .precharge_current_code_o(pre_code), .termination_current_code_o(term_code),
      .precharge_ma_o(pre_ma), .termination_ma_o(term_ma), .charge_voltage_code_o(vcode),
      .topup_duration_o(topup), .recharge_threshold_sel_o(rechg), .term_en_o(term_en),
      .wdog_period_o(wdog_per), .safety_timer_en_o(tmr_en), .fast_charge_timer_sel_o(fct),
      .thermal_limit_sel_o(therm), .warm_zone_voltage_sel_o(warm),
      .input_overvoltage_sel_o(ov_sel), .input_voltage_limit_code_o(vin_code),
      .input_voltage_limit_mv_o(vin_mv));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back({8'h00, x});
      host.rd(a);
   endtask

   task automatic settle;
      repeat (2) @(negedge clk_i);
   endtask

   task automatic pulse(input bit wd);
      @(posedge clk_i);
      if (wd) begin
         wdog_expire_i <= 1'b1;
      end else begin
         reg_rst_i <= 1'b1;
      end
      @(posedge clk_i);
      wdog_expire_i <= 1'b0;
      reg_rst_i <= 1'b0;
   endtask

   // the read watcher takes the oldest note for every valid pulse
   always @(negedge clk_i) begin
      if (reg_rvalid === 1'b1) begin
         check("rdata", {8'h00, reg_rdata}, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
      end
   end

   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == TMO) begin
         error_cnt++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      settle();
      check("pre_ma", 16'(pre_ma), 16'd40);
      check("term_ma", 16'(term_ma), 16'd60);
      check("vin_mv", 16'(vin_mv), 16'd4500);
      rd_exp(8'h03, 8'h12);
      rd_exp(8'h04, 8'h40);
      rd_exp(8'h05, 8'h9E);
      rd_exp(8'h06, 8'hE6);
      host.wr(8'h07, 8'hAA);
      rd_exp(8'h07, 8'h00);
      rd_exp(8'h02, 8'h00);
      for (int c = 0; c < 16; c++) begin
         host.wr(CCR_ADDR_CURR, {c[3:0], ~c[3:0]});
         settle();
         e = (c > 12) ? 12 : c;
         check("pre_code", 16'(pre_code), 16'(e));
         check("pre_ma", 16'(pre_ma), 16'(20 + 20 * e));
         e = (15 - c > 12) ? 12 : 15 - c;
         check("term_code", 16'(term_code), 16'(e));
         check("term_ma", 16'(term_ma), 16'(20 + 20 * e));
      end
      rd_exp(CCR_ADDR_CURR, 8'hF0);
      for (int i = 0; i < 8; i++) begin
         for (int a = 4; a < 7; a++) begin
            lfsr_r = lfsr_next(lfsr_r);
            host.wr(8'(a), lfsr_r[7:0]);
            settle();
            d = host.sent_r;
            if (a == 4) begin
               check("volt", 16'({vcode, topup, rechg}), 16'(d));
            end else if (a == 5) begin
               check("ctl1", 16'({term_en, d[6], wdog_per, tmr_en, fct, therm, warm}),
                  16'(d));
            end else begin
               check("ctl2", 16'({ov_sel, vin_code}), 16'({d[7:6], d[3:0]}));
               check("vin_mv", 16'(vin_mv), 16'(3900 + 100 * d[3:0]));
            end
            rd_exp(8'(a), d);
         end
      end
      pulse(1'b1);
      settle();
      rd_exp(8'h03, 8'h12);
      rd_exp(8'h04, 8'h40);
      rd_exp(8'h05, 8'h9E);
      rd_exp(8'h06, d);
      host.wr(CCR_ADDR_CURR, 8'h77);
      pulse(1'b0);
      settle();
      rd_exp(8'h03, 8'h12);
      rd_exp(8'h06, 8'hE6);
      check("vin_mv", 16'(vin_mv), 16'd4500);
      repeat (4) @(negedge clk_i);
      check("pending", 16'(exp_q.size()), 16'h0000);
      test_done();
   end
endmodule
